// >>> obp_pkg.sv
// Purpose: shared constants and types for the output-driver / sleep-mask register group
// Assumes: 8-bit configuration port, one clock, synchronous reset
// Notes:   register offsets are consecutive bytes starting at the low disable byte
`default_nettype none
package obp_pkg;
  // register offsets on the configuration port
  localparam logic [7:0] OBP_ADDR_DIS_LOW  = 8'h0A;  // disable vector bits 7..0
  localparam logic [7:0] OBP_ADDR_DIS_MID  = 8'h0B;  // disable vector bits 15..8
  localparam logic [7:0] OBP_ADDR_DIS_HIGH = 8'h0C;  // disable vector bits 23..16
  localparam logic [7:0] OBP_ADDR_MASK     = 8'h0D;  // sleep keep mask
  localparam logic [7:0] OBP_ADDR_CTRL     = 8'h0E;  // sync / reference / clock control
  localparam int         OBP_NUM_REGS      = 5;
  localparam logic [7:0] OBP_REG_ADDR [0:OBP_NUM_REGS-1] = '{OBP_ADDR_DIS_LOW, OBP_ADDR_DIS_MID,
                                                              OBP_ADDR_DIS_HIGH, OBP_ADDR_MASK, OBP_ADDR_CTRL};
  localparam int         OBP_IDX_MASK      = 3;      // index of the mask in the register array
  localparam int         OBP_IDX_CTRL      = 4;      // index of the control byte
  localparam logic [7:0] OBP_RESET_VALUE   = 8'h00;  // every register clears to zero
  localparam logic [7:0] OBP_UNMAPPED_READ = 8'h00;  // answer for an unmapped read
  // sleep keep mask fields
  localparam int OBP_KEEP_CLOCK_BUFFER_BIT = 3;
  localparam int OBP_KEEP_REF_AMP_BIT      = 2;
  localparam int OBP_BANDGAP_OFF_BIT       = 1;
  // control byte fields
  localparam int OBP_SYNC_PIN_FN_BIT       = 7;
  localparam int OBP_SPI_SYNC_BIT          = 6;
  localparam int OBP_SPI_SYNC_EN_BIT       = 5;
  localparam int OBP_REF_BY_REG_BIT        = 3;
  localparam int OBP_REF_SEL_MSB           = 2;
  localparam int OBP_REF_SEL_LSB           = 1;
  localparam int OBP_SINGLE_ENDED_BIT      = 0;
  // disable vector position of each data pin driver, data0 first
  localparam int OBP_NUM_DATA_PINS = 16;
  localparam int OBP_DATA_MAP [0:OBP_NUM_DATA_PINS-1] = '{0, 1, 2, 3, 4, 20, 21, 7, 8, 22, 23, 17, 16, 15, 14, 13};
  localparam int OBP_FRAME_CLOCK_POS = 12;   // frame clock driver
  // reference choice when the register owns the reference
  typedef enum logic [1:0] {
    OBP_REF_INTERNAL,
    OBP_REF_EXT_BUFFERED,
    OBP_REF_EXT_DIRECT,
    OBP_REF_UNUSED
  } obp_ref_e;
  // one configuration port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } obp_cfg_req_s;
  // analog blocks switched off while asleep
  typedef struct packed {
    logic clock_buffer_off;
    logic ref_amp_off;
    logic bandgap_off;
  } obp_sleep_s;
endpackage
`default_nettype wire

// >>> obp_cfg_byte.sv
// Purpose: one 8-bit read/write configuration byte
// Assumes: write strobe already decoded for this byte
// Notes:   holds every bit as written, reserved bits included
`default_nettype none
module obp_cfg_byte (
  input  wire logic       clk_sys_in,
  input  wire logic       reset_in,
  input  wire logic       ce_in,
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  output var  logic [7:0] q_out
);
  import obp_pkg::*;
  logic [7:0] q_reg;  // stored byte
  // store on a decoded write, frozen while the clock enable is low
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      q_reg <= OBP_RESET_VALUE;
    end else if (ce_in && wr_in) begin
      q_reg <= wdata_in;
    end
  end
  assign q_out = q_reg;
endmodule
`default_nettype wire

// >>> obp_regs.sv
// Purpose: output driver disable bytes, sleep keep mask and sync/reference control byte
// Assumes: the serial configuration port is decoded upstream into address, data and strobes
// Notes:   outputs follow register contents one cycle after the register has taken a write
`default_nettype none
// What this block does
// RQ1: 24 disable bits over three bytes
// RQ2: zero keeps driver on, one powers down
// RQ3: host disables every unused output pin
// RQ4: host disables data3 driver in serial modes
// RQ5: serial clock buffer enabled by other bits
// RQ6: data clock driver off only by separate bit
// RQ7: fixed disable bit to pin mapping
// RQ8: host writes documented per-mode byte values
// RQ9: mask bit 3 keeps clock buffer alive
// RQ10: mask bit 2 keeps reference amplifier alive
// RQ11: mask bit 1 turns bandgap off asleep
// RQ12: sleep command, mask picks blocks switched off
// RQ13: pin function bit: sleep or sync
// RQ14: reference field decoded only under register control
// RQ15: host writes zero to reserved bits
module obp_regs (
  input  wire logic                  clk_sys_in,
  input  wire logic                  reset_in,
  input  wire logic                  ce_in,
  input  wire obp_pkg::obp_cfg_req_s cfg_req_in,                  // configuration port request
  input  wire logic                  whole_chip_sleep_in,         // sleep command bit
  input  wire logic                  sync_sleep_pin_in,           // shared sync / sleep pin
  input  wire logic                  serial_clock_enable_a_in,    // serial clock buffer enable, first bit
  input  wire logic                  serial_clock_enable_b_in,    // serial clock buffer enable, second bit
  input  wire logic                  data_clock_off_in,           // data clock driver power-down bit
  output var  logic [7:0]            cfg_rdata_out,               // read data
  output var  logic                  cfg_rvalid_out,              // read data valid pulse
  output var  logic [15:0]           data_driver_off_out,         // per data pin driver off
  output var  logic                  frame_clock_driver_off_out,  // frame clock driver off
  output var  logic                  data_clock_driver_off_out,   // data clock driver off
  output var  logic                  serial_bit_clock_in_on_out,  // serial clock input buffer on
  output var  logic                  sleep_active_out,            // whole chip asleep
  output var  obp_pkg::obp_sleep_s   sleep_off_out,               // analog blocks switched off
  output var  logic                  sync_command_out,            // sync pulse or pin level
  output var  logic                  reference_pin_control_out,   // reference chosen by the pin
  output var  obp_pkg::obp_ref_e     reference_choice_out,        // reference chosen by register
  output var  logic                  reference_choice_valid_out,  // register choice in force
  output var  logic                  single_ended_clock_out       // single ended clock selected
);
  import obp_pkg::*;

  logic [7:0]  reg_q    [0:OBP_NUM_REGS-1];  // stored bytes
  logic [OBP_NUM_REGS-1:0] addr_hit;          // address decode per byte
  logic [23:0] disable_vec;                   // output driver disable vector
  logic [7:0]  keep_mask;                     // sleep keep mask
  logic [7:0]  ctrl;                          // control byte
  logic [7:0]  rd_mux;                        // selected read byte
  logic        sleep_now;                     // combined sleep request
  logic        pin_sync;                      // pin used as sync
  logic        spi_sync_edge;                 // register sync toggled while enabled
  logic        spi_sync_prev_reg;             // last seen register sync bit
  logic [15:0] data_off_next;                 // mapped data pin disables
  obp_sleep_s  sleep_off_next;                // blocks to switch off
  obp_ref_e    ref_field;                     // raw reference field

  // one byte register per address; reserved bits stored as written
  for (genvar i = 0; i < OBP_NUM_REGS; i++) begin : g_byte
    assign addr_hit[i] = (cfg_req_in.addr == OBP_REG_ADDR[i]);
    obp_cfg_byte i_obp_cfg_byte (
      .clk_sys_in (clk_sys_in),
      .reset_in   (reset_in),
      .ce_in      (ce_in),
      .wr_in      (cfg_req_in.wr && addr_hit[i]),
      .wdata_in   (cfg_req_in.wdata),
      .q_out      (reg_q[i])
    );
  end

  // the three disable bytes form one vector, low byte first
  assign disable_vec = {reg_q[2], reg_q[1], reg_q[0]};  // RQ1
  assign keep_mask   = reg_q[OBP_IDX_MASK];
  assign ctrl        = reg_q[OBP_IDX_CTRL];

  // read select; an unmapped address answers zero
  always_comb begin
    rd_mux = OBP_UNMAPPED_READ;
    for (int k = 0; k < OBP_NUM_REGS; k++) begin
      if (addr_hit[k]) begin
        rd_mux = reg_q[k];
      end
    end
  end

  // each data pin driver picks its own disable bit; a one powers the driver down
  for (genvar p = 0; p < OBP_NUM_DATA_PINS; p++) begin : g_pin
    assign data_off_next[p] = disable_vec[OBP_DATA_MAP[p]];  // RQ7 RQ2
  end

  // pin function: low selects sleep on a high pin, high selects sync
  assign pin_sync  = sync_sleep_pin_in && ctrl[OBP_SYNC_PIN_FN_BIT];                // RQ13
  assign sleep_now = whole_chip_sleep_in ||
                     (sync_sleep_pin_in && !ctrl[OBP_SYNC_PIN_FN_BIT]);             // RQ12 RQ13
  // register sync acts on any change of its bit while the enable bit is set, since it never self-clears
  assign spi_sync_edge = ctrl[OBP_SPI_SYNC_EN_BIT] && (ctrl[OBP_SPI_SYNC_BIT] != spi_sync_prev_reg);

  // mask picks what sleeps; note the bandgap bit has the opposite sense
  assign sleep_off_next.clock_buffer_off = sleep_now && !keep_mask[OBP_KEEP_CLOCK_BUFFER_BIT];  // RQ9
  assign sleep_off_next.ref_amp_off      = sleep_now && !keep_mask[OBP_KEEP_REF_AMP_BIT];       // RQ10
  assign sleep_off_next.bandgap_off      = sleep_now && keep_mask[OBP_BANDGAP_OFF_BIT];         // RQ11

  assign ref_field = obp_ref_e'(ctrl[OBP_REF_SEL_MSB:OBP_REF_SEL_LSB]);

  // configuration port read answer, one cycle after the request
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      cfg_rdata_out  <= OBP_RESET_VALUE;
      cfg_rvalid_out <= 1'b0;
    end else if (ce_in) begin
      cfg_rdata_out  <= cfg_req_in.rd ? rd_mux : OBP_UNMAPPED_READ;
      cfg_rvalid_out <= cfg_req_in.rd;
    end
  end

  // driver power-down outputs; the data clock and serial clock buffer are not in the vector
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      data_driver_off_out        <= '0;
      frame_clock_driver_off_out <= 1'b0;
      data_clock_driver_off_out  <= 1'b0;
      serial_bit_clock_in_on_out <= 1'b0;
    end else if (ce_in) begin
      data_driver_off_out        <= data_off_next;                                      // RQ2
      frame_clock_driver_off_out <= disable_vec[OBP_FRAME_CLOCK_POS];                   // RQ7
      data_clock_driver_off_out  <= data_clock_off_in;                                  // RQ6
      serial_bit_clock_in_on_out <= serial_clock_enable_a_in || serial_clock_enable_b_in; // RQ5
    end
  end

  // sleep and sync outputs
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      sleep_active_out  <= 1'b0;
      sleep_off_out     <= '0;
      sync_command_out  <= 1'b0;
      spi_sync_prev_reg <= 1'b0;
    end else if (ce_in) begin
      sleep_active_out  <= sleep_now;        // RQ12
      sleep_off_out     <= sleep_off_next;   // RQ12
      sync_command_out  <= pin_sync || spi_sync_edge;
      spi_sync_prev_reg <= ctrl[OBP_SPI_SYNC_BIT];
    end
  end

  // reference and clock-input selection; the field means nothing without register control
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      reference_pin_control_out  <= 1'b1;
      reference_choice_out       <= OBP_REF_INTERNAL;
      reference_choice_valid_out <= 1'b0;
      single_ended_clock_out     <= 1'b0;
    end else if (ce_in) begin
      reference_pin_control_out  <= !ctrl[OBP_REF_BY_REG_BIT];
      reference_choice_out       <= ref_field;
      reference_choice_valid_out <= ctrl[OBP_REF_BY_REG_BIT] && (ref_field != OBP_REF_UNUSED);  // RQ14
      single_ended_clock_out     <= ctrl[OBP_REF_BY_REG_BIT] && ctrl[OBP_SINGLE_ENDED_BIT];
    end
  end

  // checks on the register group, all in the one clock domain
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  property p_low_write;
    ce_in && cfg_req_in.wr && cfg_req_in.addr == OBP_ADDR_DIS_LOW |=> disable_vec[7:0] == $past(cfg_req_in.wdata);
  endproperty
  a_low_write: assert property (p_low_write) else $error("disable byte write lost");  // RQ1

  property p_drv_on;
    (ce_in && cfg_req_in.wr && cfg_req_in.addr == OBP_ADDR_DIS_LOW && !cfg_req_in.wdata[0]) ##1 ce_in
      |=> !data_driver_off_out[0];
  endproperty
  a_drv_on: assert property (p_drv_on) else $error("cleared bit did not enable driver");  // RQ2

  property p_pin_map;
    ce_in |=> frame_clock_driver_off_out == $past(reg_q[1][4]) && data_driver_off_out[13] == $past(reg_q[1][7])
              && data_driver_off_out[5] == $past(reg_q[2][4]) && data_driver_off_out[7] == $past(reg_q[0][7]);
  endproperty
  a_pin_map: assert property (p_pin_map) else $error("driver pin mapping wrong");  // RQ7

  property p_data_clock_out;
    ce_in |=> data_clock_driver_off_out == $past(data_clock_off_in);
  endproperty
  a_data_clock_out: assert property (p_data_clock_out) else $error("data clock driver not following its bit");  // RQ6

  property p_serclk;
    ce_in && !serial_clock_enable_a_in && !serial_clock_enable_b_in |=> !serial_bit_clock_in_on_out;
  endproperty
  a_serclk: assert property (p_serclk) else $error("serial clock buffer on without enable");  // RQ5

  property p_clkbuf;
    ce_in |=> sleep_off_out.clock_buffer_off ==
              $past((whole_chip_sleep_in || (sync_sleep_pin_in && !ctrl[OBP_SYNC_PIN_FN_BIT])) &&
                    !keep_mask[OBP_KEEP_CLOCK_BUFFER_BIT]);
  endproperty
  a_clkbuf: assert property (p_clkbuf) else $error("clock buffer sleep wrong");  // RQ9

  property p_refamp;
    ce_in && whole_chip_sleep_in && !keep_mask[OBP_KEEP_REF_AMP_BIT] |=> sleep_off_out.ref_amp_off;
  endproperty
  a_refamp: assert property (p_refamp) else $error("reference amplifier not slept");  // RQ10

  property p_bandgap;
    ce_in && !keep_mask[OBP_BANDGAP_OFF_BIT] |=> !sleep_off_out.bandgap_off;
  endproperty
  a_bandgap: assert property (p_bandgap) else $error("bandgap off with mask bit clear");  // RQ11

  // the inverted-sense bit must actually switch the bandgap off, not just never do so
  property p_bandgap_on;
    ce_in && whole_chip_sleep_in && keep_mask[OBP_BANDGAP_OFF_BIT] |=> sleep_off_out.bandgap_off;
  endproperty
  a_bandgap_on: assert property (p_bandgap_on) else $error("bandgap kept on with mask bit set");  // RQ11

  // the sleep command alone is enough, whatever the pin does
  property p_sleep_cmd;
    ce_in && whole_chip_sleep_in |=> sleep_active_out;
  endproperty
  a_sleep_cmd: assert property (p_sleep_cmd) else $error("sleep command not followed");  // RQ12

  property p_pin_sleep;
    ce_in && sync_sleep_pin_in && !ctrl[OBP_SYNC_PIN_FN_BIT] |=> sleep_active_out;
  endproperty
  a_pin_sleep: assert property (p_pin_sleep) else $error("pin did not force sleep");  // RQ13

  property p_ref_gate;
    ce_in && !ctrl[OBP_REF_BY_REG_BIT] |=> !reference_choice_valid_out && reference_pin_control_out;
  endproperty
  a_ref_gate: assert property (p_ref_gate) else $error("reference field used without register control");  // RQ14

  c_sleep: cover property (ce_in && sleep_now ##1 sleep_off_out.clock_buffer_off);
  c_sync:  cover property (ce_in && spi_sync_edge ##1 sync_command_out);
  c_read:  cover property (ce_in && cfg_req_in.rd && addr_hit[OBP_IDX_CTRL] ##1 cfg_rvalid_out);
endmodule
`default_nettype wire

// >>> obp_regs_test.sv
// Purpose: self-checking bench for the disable bytes, sleep mask and control byte
// Assumes: one 250 MHz clock, synchronous active-high reset, strobes held one cycle
// Notes:   expectations come from a bench-side shadow of every register
`default_nettype none
module obp_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  import obp_pkg::*;
  logic               clk_sys_in = 1'b0;  // system clock
  logic               reset_in   = 1'b1;  // held high at start
  logic               ce_in      = 1'b1;  // clock enable
  obp_cfg_req_s       cfg_req    = '0;    // configuration request
  logic               sleep_cmd  = 1'b0;  // sleep command level
  logic               pin        = 1'b0;  // shared sync / sleep pin
  logic               en_a       = 1'b0;  // serial clock enable a
  logic               en_b       = 1'b0;  // serial clock enable b
  logic               dco        = 1'b0;  // data clock off bit
  logic [7:0]         rdata;              // read data
  logic               rvalid;             // read valid pulse
  logic [15:0]        drv_off;            // data driver off vector
  logic               frame_clock_out_off;           // frame clock driver off
  logic               data_clock_out_off;           // data clock driver off
  logic               sbc_on;             // serial clock buffer on
  logic               slp;                // asleep
  obp_sleep_s         slp_off;            // blocks switched off
  logic               sync;               // sync command
  logic               ref_pin;            // pin owns reference
  obp_ref_e           ref_sel;            // register reference choice
  logic               ref_ok;             // register choice in force
  logic               se_clk;             // single-ended clock
  logic [7:0]         shadow [0:4];       // expected register contents
  int                 err_count = 0;
  int                 n_tests   = 0;
  // ordinary cases: address and byte written, read back and decoded
  logic [15:0]        rows [0:16] = '{16'h0A60, 16'h0B1E, 16'h0C0C, 16'h0A7F, 16'h0BFE, 16'h0AFF,
                                      16'h0BEF, 16'h0CFC, 16'h0CFD, 16'h0A08, 16'h0D0E, 16'h0D08,
                                      16'h0E08, 16'h0E0D, 16'h0E0F, 16'h0E0A, 16'h0E2C};
  always #2 clk_sys_in = ~clk_sys_in;
  obp_regs i_obp_regs (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .ce_in(ce_in), .cfg_req_in(cfg_req),
    .whole_chip_sleep_in(sleep_cmd), .sync_sleep_pin_in(pin), .serial_clock_enable_a_in(en_a),
    .serial_clock_enable_b_in(en_b), .data_clock_off_in(dco), .cfg_rdata_out(rdata), .cfg_rvalid_out(rvalid),
    .data_driver_off_out(drv_off), .frame_clock_driver_off_out(frame_clock_out_off), .data_clock_driver_off_out(data_clock_out_off),
    .serial_bit_clock_in_on_out(sbc_on), .sleep_active_out(slp), .sleep_off_out(slp_off),
    .sync_command_out(sync), .reference_pin_control_out(ref_pin), .reference_choice_out(ref_sel),
    .reference_choice_valid_out(ref_ok), .single_ended_clock_out(se_clk));
  // pin order of the disable vector, worked out independently of the design
  function automatic logic [15:0] pin_map(input logic [23:0] v);
    return {v[13], v[14], v[15], v[16], v[17], v[23], v[22], v[8], v[7], v[21], v[20], v[4:0]};
  endfunction
  task automatic chk_vec(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_vec(what, {15'h0, exp}, {15'h0, got});
  endtask
  task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in) cfg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys_in) cfg_req <= '0;
    if (a >= 8'h0A && a <= 8'h0E) shadow[a - 8'h0A] = d;
  endtask
  task automatic check_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in) cfg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys_in) cfg_req <= '0;
    #1;  // the answer stands for one cycle only, right after the edge that took the read
    chk_bit("rvalid", 1'b1, rvalid);
    chk_vec("rdata", {8'h00, exp}, {8'h00, rdata});
  endtask
  // let level inputs and register writes reach the registered outputs
  task automatic settle();
    repeat (3) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic check_derived();
    logic [23:0] v;
    logic [7:0]  c;
    logic [7:0]  m;
    logic        s;
    v = {shadow[2], shadow[1], shadow[0]};
    c = shadow[4];
    m = shadow[3];
    s = sleep_cmd | (pin & ~c[7]);
    chk_vec("drivers", pin_map(v), drv_off);
    chk_bit("frame", v[12], frame_clock_out_off);
    chk_bit("data_clock_out", dco, data_clock_out_off);
    chk_bit("sbc", en_a | en_b, sbc_on);
    chk_bit("sleep", s, slp);
    chk_vec("sleep_off", {13'h0, s & ~m[3], s & ~m[2], s & m[1]}, {13'h0, slp_off});
    chk_bit("sync", c[7] & pin, sync);
    chk_bit("ref_pin", ~c[3], ref_pin);
    chk_vec("ref_sel", {14'h0, c[2:1]}, {14'h0, ref_sel});
    chk_bit("ref_ok", c[3] & (c[2:1] != 2'b11), ref_ok);
    chk_bit("se_clk", c[3] & c[0], se_clk);
  endtask
  task automatic end_sim();
    $display("errors %0d of %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog: the whole sequence needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    err_count++;
    end_sim();
  end
  initial begin
    for (int i = 0; i < 5; i++) shadow[i] = 8'h00;
    repeat (5) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    settle();
    check_derived();
    for (int i = 0; i < 5; i++) check_read(8'h0A + i[7:0], 8'h00);
    cfg_write(8'h09, 8'hFF);
    cfg_write(8'h0F, 8'hFF);
    check_read(8'h0F, OBP_UNMAPPED_READ);
    check_read(8'h0A, 8'h00);
    // ordinary cases: ten mode bytes, two mask and five control patterns
    for (int r = 0; r < 17; r++) begin
      cfg_write(rows[r][15:8], rows[r][7:0]);
      check_read(rows[r][15:8], rows[r][7:0]);
      check_derived();
    end
    // sleep mask under a commanded sleep, then awake again
    @(posedge clk_sys_in) sleep_cmd <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      cfg_write(8'h0D, 8'(m << 1));
      settle();
      check_derived();
    end
    @(posedge clk_sys_in) sleep_cmd <= 1'b0;
    settle();
    check_derived();
    // shared pin in both roles
    for (int p = 0; p < 2; p++) begin
      cfg_write(8'h0E, p[0] ? 8'h80 : 8'h00);
      pin <= 1'b1;
      settle();
      check_derived();
      @(posedge clk_sys_in) pin <= 1'b0;
    end
    // register sync: a change of the sync bit while enabled gives a one-cycle pulse
    cfg_write(8'h0E, 8'h20);
    cfg_write(8'h0E, 8'h60);
    @(posedge clk_sys_in) #1;
    chk_bit("sync_pulse", 1'b1, sync);
    @(posedge clk_sys_in) #1;
    chk_bit("sync_end", 1'b0, sync);
    // serial clock and data clock controls with all disable bytes set
    cfg_write(8'h0A, 8'hFF);
    cfg_write(8'h0B, 8'hFF);
    cfg_write(8'h0C, 8'hFF);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_sys_in) {en_a, en_b, dco} <= k[2:0];
      settle();
      check_derived();
    end
    // clock enable low: a write is ignored
    @(posedge clk_sys_in) ce_in <= 1'b0;
    @(posedge clk_sys_in) cfg_req <= '{wr: 1'b1, rd: 1'b0, addr: 8'h0A, wdata: 8'h55};
    dco <= 1'b0;
    @(posedge clk_sys_in) cfg_req <= '0;
    #1;
    chk_bit("frozen", 1'b1, data_clock_out_off);
    @(posedge clk_sys_in) ce_in <= 1'b1;
    check_read(8'h0A, 8'hFF);
    // second reset in mid-run clears everything
    @(posedge clk_sys_in) reset_in <= 1'b1;
    {en_a, en_b, dco} <= 3'b000;
    repeat (5) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 5; i++) shadow[i] = 8'h00;
    settle();
    check_derived();
    check_read(8'h0E, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
